//--- core/fault_filter.sv
// Per-channel fault filter: qualifies a raw fault held for LEN cycles.
`include "relay_diag_consts.svh"
module fault_filter #(
	parameter logic [`CNT_W-1:0] LEN = `CNT_W'(`FAULT_FILTER_CYCLES)
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic raw,
	output logic qual
);
	logic [`CNT_W-1:0] cnt_ff;
	logic [`CNT_W-1:0] nxt_cnt;
	logic qual_ff;
	logic nxt_qual;
	wire at_end = (cnt_ff == LEN - 16'd1);

	// R22 restart on deassert
	// The count restarts whenever the raw condition drops, so glitches never add up.
	assign nxt_cnt = !raw ? '0 : (at_end ? cnt_ff : cnt_ff + 16'd1);
	assign nxt_qual = raw & (at_end | qual_ff);

	// Counter and qualified flag.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff <= '0;
			qual_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			qual_ff <= nxt_qual;
		end
	end
	assign qual = qual_ff;

	// R5 qualify after full time
	filter_rise_a: assert property (@(posedge clk) disable iff (!arst_n) // R5
		$rose(qual_ff) |-> $past(raw) && ($past(cnt_ff) == LEN - 16'd1))
		else $error("Fault qualified before the filter time ran out.");
	// R22 restart on drop
	filter_drop_a: assert property (@(posedge clk) disable iff (!arst_n) // R22
		!raw |=> (cnt_ff == '0) && !qual_ff)
		else $error("Filter did not restart when the fault dropped.");
endmodule

//--- core/relay_diag_consts.svh
// Constants for the relay driver fault and diagnostics block.
`ifndef RELAY_DIAG_CONSTS_SVH
`define RELAY_DIAG_CONSTS_SVH

// ****************************************************************
// Geometry
// ****************************************************************
`define CH_NUM 8
`define CNT_W 16

// ****************************************************************
// Timing
// ****************************************************************
`define SYS_CLK_PERIOD_NS 50
// Fault filter time in nanoseconds, 280 us.
`define FAULT_FILTER_NS 280000
// Least time, so the cycle count rounds up.
`define FAULT_FILTER_CYCLES ((`FAULT_FILTER_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)

// ****************************************************************
// Synchroniser bit positions and reset value
// ****************************************************************
`define SY_OL_LSB 0
`define SY_OC_LSB 8
`define SY_OT 16
`define SY_PDOFF 17
`define SY_SLD 18
`define SY_DIN 19
`define SY_CS 20
`define SY_SCLK 21
`define SY_W 22
// Chip select idles high, everything else low.
`define SY_RST 22'h10_0000

`endif

//--- core/relay_diag_pkg.sv
// Types shared by the relay driver fault and diagnostics block.
package relay_diag_pkg;
	typedef logic [7:0] chan_vec_t;
	// Serial frame states, Gray coded along idle, frame, latch.
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FRAME = 2'b01,
		ST_LATCH = 2'b11
	} link_state_t;
endpackage

//--- core/relay_driver_diag.sv
// Fault protection, diagnostics and serial link of an eight-channel relay driver.
// What this block does
// R1: Status bit n reports channel n+1.
// R2: Off channel: low normal, high on fault.
// R3: On channel: high normal, low when shorted.
// R4: Host writes, waits filter time, rewrites, reads.
// R5: Short protection only after full filter time.
// R6: Latch-off disabled: hold current limit until clear.
// R7: Latch-off enabled: overloaded channel latched off.
// R8: Latched channel re-enabled only by next word.
// R9: Persisting short: flag released, then reasserts.
// R10: Open-load detection only with pulldown enabled.
// R11: Open-load checked only on off channels.
// R12: Over-temperature: all off, flag, no filter.
// R13: Reset clears everything, outputs off.
// R14: Pulldowns disabled during reset.
// R15: Latched flag on filtered short or open.
// R16: Flag immediate on thermal shutdown.
// R17: Flag released on chip select rise.
// R18: Daisy chain: shared select, output to input.
// R19: Status loaded on select fall, shifted out.
// R20: Status cleared on select rise.
// R21: D7..D0 to channels 8..1, latched on rise.
// R22: Per-channel filter counter restarting on drop.
`include "relay_diag_consts.svh"
module relay_driver_diag #(
	parameter logic [`CNT_W-1:0] FILTER_CYCLES = `CNT_W'(`FAULT_FILTER_CYCLES)
) (
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic SCLK,
	input wire logic CS_N,
	input wire logic DIN,
	input wire logic SHORT_LATCHOFF_DISABLE,
	input wire logic PULLDOWN_CURRENT_DISABLE,
	input wire relay_diag_pkg::chan_vec_t OVER_CURRENT,
	input wire relay_diag_pkg::chan_vec_t OPEN_LOAD_LOW,
	input wire logic OVER_TEMP,
	output relay_diag_pkg::chan_vec_t OUT_ON,
	output relay_diag_pkg::chan_vec_t CURRENT_LIMIT,
	output relay_diag_pkg::chan_vec_t PULLDOWN_EN,
	output logic DOUT,
	output logic FLAG_O,
	output logic FLAG_OE
);
	import relay_diag_pkg::*;

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	logic [`SY_W-1:0] sy1_ff;
	logic [`SY_W-1:0] sy2_ff;
	logic sclk_prev_ff;
	logic cs_prev_ff;
	wire [`SY_W-1:0] raw_in = {SCLK, CS_N, DIN, SHORT_LATCHOFF_DISABLE,
		PULLDOWN_CURRENT_DISABLE, OVER_TEMP, OVER_CURRENT, OPEN_LOAD_LOW};

	// Two flops on every pin; only the second stage feeds any logic.
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			sy1_ff <= `SY_RST;
			sy2_ff <= `SY_RST;
			sclk_prev_ff <= 1'b0;
			cs_prev_ff <= 1'b1;
		end else begin
			sy1_ff <= raw_in;
			sy2_ff <= sy1_ff;
			sclk_prev_ff <= sy2_ff[`SY_SCLK];
			cs_prev_ff <= sy2_ff[`SY_CS];
		end
	end

	// Named views of the synchronised pins and their edges.
	wire sclk_s = sy2_ff[`SY_SCLK];
	wire cs_s = sy2_ff[`SY_CS];
	wire din_s = sy2_ff[`SY_DIN];
	wire sld_s = sy2_ff[`SY_SLD];
	wire pd_off_s = sy2_ff[`SY_PDOFF];
	wire ot_s = sy2_ff[`SY_OT];
	wire chan_vec_t oc_s = sy2_ff[`SY_OC_LSB +: `CH_NUM];
	wire chan_vec_t ol_s = sy2_ff[`SY_OL_LSB +: `CH_NUM];
	wire cs_fall = cs_prev_ff & ~cs_s;
	wire cs_rise = ~cs_prev_ff & cs_s;
	wire sclk_rise = ~cs_s & ~sclk_prev_ff & sclk_s;
	wire sclk_fall = ~cs_s & sclk_prev_ff & ~sclk_s;

	// ****************************************************************
	// Serial frame control
	// ****************************************************************
	link_state_t state_ff;
	link_state_t nxt_state;
	chan_vec_t shreg_ff;
	chan_vec_t nxt_shreg;
	chan_vec_t ctrl_ff;
	chan_vec_t nxt_ctrl;
	chan_vec_t fault_ff;
	chan_vec_t nxt_fault;
	chan_vec_t latched_ff;
	chan_vec_t nxt_latched;
	logic dout_ff;
	logic nxt_dout;
	logic flag_ff;
	logic nxt_flag;
	wire latch_now = (state_ff == ST_LATCH);

	// The latch state lasts one cycle, so a rise is applied exactly once.
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (cs_fall) begin
					nxt_state = ST_FRAME;
				end
			end
			ST_FRAME: begin
				if (cs_rise) begin
					nxt_state = ST_LATCH;
				end
			end
			ST_LATCH: begin
				nxt_state = cs_fall ? ST_FRAME : ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// ****************************************************************
	// Fault qualification
	// ****************************************************************
	chan_vec_t short_raw;
	chan_vec_t open_raw;
	chan_vec_t short_q;
	chan_vec_t open_q;

	// R11 off channels only
	// R10 pulldown must be enabled
	// The comparator is meaningless while the channel sinks current.
	assign open_raw = ol_s & ~ctrl_ff & {`CH_NUM{~pd_off_s}};
	// A short only shows while the switch is actually conducting.
	assign short_raw = oc_s & OUT_ON;

	// R5 short filtered before protection
	// R22 two filters per channel, short and open
	genvar gi;
	generate
		for (gi = 0; gi < `CH_NUM; gi++) begin : g_chan
			fault_filter #(.LEN(FILTER_CYCLES)) u_short (
				.clk(SYS_CLK),
				.arst_n(ARST_N),
				.raw(short_raw[gi]),
				.qual(short_q[gi])
			);
			fault_filter #(.LEN(FILTER_CYCLES)) u_open (
				.clk(SYS_CLK),
				.arst_n(ARST_N),
				.raw(open_raw[gi]),
				.qual(open_q[gi])
			);
		end
	endgenerate

	wire chan_vec_t new_fault = short_q | (open_q & ~ctrl_ff);

	// ****************************************************************
	// Shift register, control word and status
	// ****************************************************************
	// R1 bit n is channel n+1
	// R2 off: high on fault
	// R3 on: low on fault
	wire chan_vec_t status_word = ctrl_ff ^ fault_ff;

	// R19 load at fall, shift
	// R18 input shifts through
	// One register serves both directions, so a chained part passes data on.
	assign nxt_shreg = cs_fall ? status_word :
		(sclk_rise ? {shreg_ff[6:0], din_s} : shreg_ff);
	assign nxt_dout = cs_fall ? status_word[7] :
		(sclk_fall ? shreg_ff[7] : dout_ff);

	// R21 latch word at rise
	assign nxt_ctrl = latch_now ? shreg_ff : ctrl_ff;

	// R20 clear status at rise
	// A fault found in the clearing cycle still lands.
	assign nxt_fault = (latch_now ? '0 : fault_ff) | new_fault;

	// R7 latch off overloaded
	// R8 next word re-enables
	// R9 refilter after re-enable
	// After release the raw short restarts its filter, so the flag stays low a filter time.
	assign nxt_latched = (latch_now ? '0 : latched_ff) | (short_q & {`CH_NUM{~sld_s}});

	// R15 flag on filtered fault
	// R16 immediate on overtemp
	// R17 release at rise
	assign nxt_flag = (flag_ff & ~latch_now) | (|new_fault) | ot_s;

	// R13 async clear
	// Every latch, register and output goes to its off value on reset.
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_ff <= ST_IDLE;
			shreg_ff <= '0;
			ctrl_ff <= '0;
			fault_ff <= '0;
			latched_ff <= '0;
			dout_ff <= 1'b0;
			flag_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			shreg_ff <= nxt_shreg;
			ctrl_ff <= nxt_ctrl;
			fault_ff <= nxt_fault;
			latched_ff <= nxt_latched;
			dout_ff <= nxt_dout;
			flag_ff <= nxt_flag;
		end
	end

	// ****************************************************************
	// Output drive
	// ****************************************************************
	chan_vec_t out_on_ff;
	chan_vec_t limit_ff;
	chan_vec_t pd_ff;
	logic flag_o_ff;

	// R12 overtemp all off
	// R6 current limit mode
	// Thermal shutdown overrides both drive and current limit; limit ends with the overload.
	wire chan_vec_t nxt_on = ctrl_ff & ~latched_ff & ~nxt_latched & {`CH_NUM{~ot_s}};
	wire chan_vec_t nxt_limit = short_q & nxt_on & {`CH_NUM{sld_s}};
	// R14 pulldowns off in reset
	wire chan_vec_t nxt_pd = ~ctrl_ff & {`CH_NUM{~pd_off_s}};

	// Registered outputs.
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			out_on_ff <= '0;
			limit_ff <= '0;
			pd_ff <= '0;
			flag_o_ff <= 1'b0;
		end else begin
			out_on_ff <= nxt_on;
			limit_ff <= nxt_limit;
			pd_ff <= nxt_pd;
			flag_o_ff <= 1'b0;
		end
	end

	assign OUT_ON = out_on_ff;
	assign CURRENT_LIMIT = limit_ff;
	assign PULLDOWN_EN = pd_ff;
	assign DOUT = dout_ff;
	assign FLAG_O = flag_o_ff;
	assign FLAG_OE = flag_ff;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);

	sequence s_select_fall;
		cs_fall;
	endsequence
	sequence s_status_ready;
		##1 (shreg_ff == $past(status_word)) && (dout_ff == $past(status_word[7]));
	endsequence

	// R19 status load check
	status_load_a: assert property (s_select_fall |-> s_status_ready) // R19
		else $error("Status not loaded at select fall.");
	// R21 word latch check
	word_latch_a: assert property (cs_rise |-> ##1 latch_now ##1 (ctrl_ff == $past(shreg_ff))) // R21
		else $error("Control word not latched at select rise.");
	// R12 thermal shutdown check
	thermal_off_a: assert property (ot_s |=> (OUT_ON == '0) && FLAG_OE) // R12
		else $error("Thermal shutdown did not switch off and flag.");
	// R15 flag raise check
	flag_fault_a: assert property ((|new_fault) |=> FLAG_OE) // R15
		else $error("Flag not raised on qualified fault.");
	// R17 flag release check
	flag_release_a: assert property (latch_now && !(|new_fault) && !ot_s |=> !FLAG_OE) // R17
		else $error("Flag not released at select rise.");
	// R7 overload latch check
	latch_off_a: assert property ((short_q != '0) && !sld_s |=> // R7
		((latched_ff & $past(short_q)) == $past(short_q)) ##1 ((OUT_ON & $past(short_q, 2)) == '0))
		else $error("Overloaded channel not latched off.");
	// R8 latch hold check
	latch_hold_a: assert property (!latch_now |=> (($past(latched_ff) & ~latched_ff) == '0)) // R8
		else $error("Latched channel released without a new word.");
	// R6 no latch in limit mode
	// A new word may still clear older latches here, so only new latch bits are refused.
	limit_mode_a: assert property (sld_s && !ot_s && (short_q != '0) |=> // R6
		((latched_ff & ~$past(latched_ff)) == '0))
		else $error("Channel latched off with latch-off disabled.");
	// R10 open-load gate check
	open_gate_a: assert property (pd_off_s |=> ##1 (open_q == '0)) // R10
		else $error("Open-load flagged with pulldown disabled.");
	// R10 pulldown source gate
	pulldown_gate_a: assert property (pd_off_s |=> (PULLDOWN_EN == '0)) // R10
		else $error("Pulldown enabled while disabled by input.");
	// R6 limit ends on shutdown
	limit_clear_a: assert property (ot_s |=> (CURRENT_LIMIT == '0)) // R6
		else $error("Current limit kept during thermal shutdown.");
	// R15 flag stays latched
	flag_hold_a: assert property (flag_ff && !latch_now |=> FLAG_OE) // R15
		else $error("Fault flag dropped without a select rise.");
	// R19 status shifted out
	dout_shift_a: assert property (sclk_fall && !cs_fall |=> (dout_ff == $past(shreg_ff[7]))) // R19
		else $error("Serial output did not shift on clock fall.");
endmodule

//--- dv/host_serial_model.sv
// Host controller model that drives the four-wire serial link of the relay driver.
module host_serial_model (
	input wire logic clk,
	input wire logic dout,
	output logic sclk,
	output logic cs_n,
	output logic din
);
	timeunit 1ns;
	timeprecision 1ns;

	// ****************************************************************
	// Link idle state
	// ****************************************************************
	// The serial clock stands low outside frames.
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
	end

	// One frame: MSB first in, status captured just before each falling SCLK.
	// Four system clocks per level keeps each level above the three needed.
	// one bitstream
	task automatic shift(input int n, input logic [15:0] wd, output logic [15:0] rd);
		rd = 16'h0000;
		@(negedge clk);
		cs_n = 1'b0;
		repeat (8) @(negedge clk);
		for (int i = n - 1; i >= 0; i--) begin
			din = wd[i];
			repeat (4) @(negedge clk);
			sclk = 1'b1;
			repeat (4) @(negedge clk);
			rd = {rd[14:0], dout};
			sclk = 1'b0;
		end
		repeat (4) @(negedge clk);
		cs_n = 1'b1;
		// A released data line must not keep showing the last bit.
		din = ~din;
		repeat (8) @(negedge clk);
	endtask

	// Single device word.
	task automatic xfer8(input logic [7:0] wd, output logic [7:0] rd);
		logic [15:0] r;
		shift(8, {8'h00, wd}, r);
		rd = r[7:0];
	endtask

	// Two chained words: the first byte out is our status, the second the echo.
	task automatic xfer16(input logic [15:0] wd, output logic [15:0] rd);
		shift(16, wd, rd);
	endtask
endmodule

//--- dv/test_relay_driver_diag.sv
// Self-checking testbench of the relay driver fault and diagnostics block.
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; \
	$display("FAIL t=%0t got %h exp %h", $time, a, e); end end
module test_relay_driver_diag;
	timeunit 1ns;
	timeprecision 1ns;
	import relay_diag_pkg::*;

	logic clk, arst_n, sclk, cs_n, din, sld, pd_off, ot, dout, flag_o, flag_oe;
	chan_vec_t oc, ol, on, lim, pd, st;
	logic [15:0] w;
	int fails = 0;
	int total_checks = 0;
	int cycles = 0;

	// Short filter so each fault qualifies in tens of cycles.
	relay_driver_diag #(.FILTER_CYCLES(16'd16)) dut_u (.SYS_CLK(clk), .ARST_N(arst_n),
		.SCLK(sclk), .CS_N(cs_n), .DIN(din), .SHORT_LATCHOFF_DISABLE(sld),
		.PULLDOWN_CURRENT_DISABLE(pd_off), .OVER_CURRENT(oc), .OPEN_LOAD_LOW(ol),
		.OVER_TEMP(ot), .OUT_ON(on), .CURRENT_LIMIT(lim), .PULLDOWN_EN(pd),
		.DOUT(dout), .FLAG_O(flag_o), .FLAG_OE(flag_oe));

	host_serial_model host_u (.clk(clk), .dout(dout), .sclk(sclk), .cs_n(cs_n), .din(din));

	// ****************************************************************
	// Clock, timeout and verdict
	// ****************************************************************
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// The whole run needs about 1300 cycles, so this ceiling only trips on a hang.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			close_out();
		end
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	// ****************************************************************
	// Test sequence
	// ****************************************************************
	initial begin
		arst_n = 1'b0; sld = 1'b0; pd_off = 1'b0; oc = 8'h00; ol = 8'h00; ot = 1'b0;
		cyc(5);
		`CHK(on, 8'h00)
		`CHK(pd, 8'h00)
		`CHK(flag_oe, 1'b0)
		arst_n = 1'b1;
		cyc(4);
		host_u.xfer8(8'ha5, st);
		`CHK(on, 8'ha5)
		`CHK(pd, 8'h5a)
		host_u.xfer8(8'ha5, st);
		`CHK(st, 8'ha5)
		$display("test basic done");
		// Open load on an on channel, then with pulldowns disabled, then enabled.
		ol = 8'h01; cyc(40);
		`CHK(flag_oe, 1'b0)
		pd_off = 1'b1; ol = 8'h02; cyc(40);
		`CHK(flag_oe, 1'b0)
		`CHK(pd, 8'h00)
		pd_off = 1'b0; cyc(40);
		`CHK(flag_oe, 1'b1)
		ol = 8'h00; cyc(6);
		host_u.xfer8(8'ha5, st);
		`CHK(st, 8'ha7)
		`CHK(flag_oe, 1'b0)
		host_u.xfer8(8'ha5, st);
		`CHK(st, 8'ha5)
		$display("test open load done");
		// Two pulses each below the filter but longer together.
		oc = 8'h01; cyc(12); oc = 8'h00; cyc(3); oc = 8'h01; cyc(12); oc = 8'h00; cyc(6);
		`CHK(flag_oe, 1'b0)
		`CHK(on, 8'ha5)
		oc = 8'h01; cyc(40);
		`CHK(on, 8'ha4)
		`CHK(flag_oe, 1'b1)
		oc = 8'h00; cyc(40);
		`CHK(on, 8'ha4)
		host_u.xfer8(8'ha5, st);
		`CHK(st, 8'ha4)
		`CHK(on, 8'ha5)
		oc = 8'h01; cyc(40);
		host_u.xfer8(8'ha5, st);
		`CHK(flag_oe, 1'b0)
		cyc(40);
		`CHK(flag_oe, 1'b1)
		`CHK(on, 8'ha4)
		$display("test latch off done");
		sld = 1'b1;
		host_u.xfer8(8'ha5, st);
		cyc(40);
		`CHK(lim, 8'h01)
		`CHK(on, 8'ha5)
		oc = 8'h00; cyc(10);
		`CHK(lim, 8'h00)
		host_u.xfer8(8'ha5, st);
		`CHK(flag_oe, 1'b0)
		$display("test current limit done");
		ot = 1'b1; cyc(5);
		`CHK(on, 8'h00)
		`CHK(flag_oe, 1'b1)
		`CHK(flag_o, 1'b0)
		ot = 1'b0; cyc(5);
		`CHK(on, 8'ha5)
		$display("test thermal done");
		host_u.xfer16(16'h3c5a, w);
		`CHK(w[15:8], 8'ha5)
		`CHK(w[7:0], 8'h3c)
		`CHK(on, 8'h5a)
		$display("test chain done");
		arst_n = 1'b0; cyc(1);
		`CHK(on, 8'h00)
		`CHK(pd, 8'h00)
		`CHK(flag_oe, 1'b0)
		arst_n = 1'b1; cyc(4);
		host_u.xfer8(8'h00, st);
		`CHK(st, 8'h00)
		$display("test reset done");
		close_out();
	end
endmodule
